// *** core/smart_card_regs.vh ***
// register map, fields, reset values and timing counts of the card port
`ifndef SMART_CARD_REGS_VH
`define SMART_CARD_REGS_VH

// register indexes; byte address is four times the index
`define SC_IDX_MODE       20'hfffb0
`define SC_IDX_DIV        20'hfffb1
`define SC_IDX_CTRL       20'hfffb2
`define SC_IDX_TXH        20'hfffb3
`define SC_IDX_STAT       20'hfffb4
`define SC_IDX_RXH        20'hfffb5
`define SC_IDX_CMS        20'hfffb6

// reset values
`define SC_RST_MODE       8'h00
`define SC_RST_DIV        8'hff
`define SC_RST_CTRL       8'h00
`define SC_RST_TXH        8'hff
`define SC_RST_RXH        8'h00
`define SC_RST_CMS        8'hf2
`define SC_RST_ORDER      1'b0
`define SC_RST_INV        1'b0
`define SC_RST_EN         1'b0

// serial_mode_control fields
`define SC_M_ALT          7
`define SC_M_ODD          4
`define SC_M_CLKSEL_HI    1
`define SC_M_CLKSEL_LO    0

// serial_control fields
`define SC_C_TXEN         5
`define SC_C_RXEN         4
`define SC_C_CLKHI        1
`define SC_C_CLKLO        0

// serial_status_flags fields
`define SC_S_TXEMPTY      7
`define SC_S_RXFULL       6
`define SC_S_OVERRUN      5
`define SC_S_ERRSIG       4
`define SC_S_PARERR       3
`define SC_S_TXEND        2

// card_mode_select fields; other bits read as one
`define SC_K_ORDER        3
`define SC_K_INV          2
`define SC_K_EN           0
`define SC_K_FIXED        8'hf2

// prescaler top values for the four clock selections
`define SC_PRE_TOP0       6'h00
`define SC_PRE_TOP1       6'h03
`define SC_PRE_TOP2       6'h0f
`define SC_PRE_TOP3       6'h3f

// baud ticks per half etu; card clock toggles once per tick
`define SC_TICKS_HALF_ETU 9'd372

// frame points in half etu from the start bit leading edge
`define SC_H_START_CHK    5'd1
`define SC_H_DATA_LAST    5'd17
`define SC_H_PARITY       5'd18
`define SC_H_RX_PAR       5'd19
`define SC_H_RELEASE      5'd20
`define SC_H_ERR_ON       5'd21
`define SC_H_ERR_SAMP     5'd22
`define SC_H_END_ALT      5'd22
`define SC_H_ERR_OFF      5'd23
`define SC_H_END_NORM     5'd25
`define SC_H_RETRY        5'd27

`endif

// *** core/baud_tick_gen.v ***
// baud rate generator: prescaler plus divisor, one pulse per tick
`timescale 1ns/10ps
`include "smart_card_regs.vh"
module baud_tick_gen #(
  parameter DIV_W = 8
) (
  // clock and reset
  input  wire             core_clk,
  input  wire             rst,
  // control
  input  wire             run,
  input  wire [1:0]       clkSel,
  input  wire [DIV_W-1:0] divisor,
  // tick out
  output reg              tick
);

  reg  [5:0]       pre_reg;
  reg  [DIV_W-1:0] cnt_reg;
  reg  [5:0]       preTop;
  wire             preHit;

  always @* begin
    case (clkSel)
      2'd0:    preTop = `SC_PRE_TOP0;
      2'd1:    preTop = `SC_PRE_TOP1;
      2'd2:    preTop = `SC_PRE_TOP2;
      default: preTop = `SC_PRE_TOP3;
    endcase
  end

  assign preHit = (pre_reg >= preTop);

  always @(posedge core_clk) begin
    if (rst || !run) begin
      pre_reg <= 6'h00;
      cnt_reg <= {DIV_W{1'b0}};
      tick    <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (preHit) begin
        pre_reg <= 6'h00;
        if (cnt_reg >= divisor) begin
          cnt_reg <= {DIV_W{1'b0}};
          tick    <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + {{(DIV_W-1){1'b0}}, 1'b1};
        end
      end else begin
        pre_reg <= pre_reg + 6'h01;
      end
    end
  end

endmodule // baud_tick_gen

// *** core/smart_card_serial_mode.v ***
// smart card serial channel with apb registers and open-drain data line
`timescale 1ns/10ps
`include "smart_card_regs.vh"
module smart_card_serial_mode (
  // clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // apb slave
  input  wire [21:0] paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // shared open-drain data line
  input  wire        dataIn,
  output reg         dataOut,
  output reg         dataOe,
  // card clock pin
  output reg         cardClkOut,
  output reg         cardClkOe
);

  localparam TX_IDLE = 1'b0;
  localparam TX_RUN  = 1'b1;
  localparam RX_IDLE = 1'b0;
  localparam RX_RUN  = 1'b1;

  reg  [7:0]  serialModeCtl_reg;
  reg  [7:0]  bitRateDiv_reg;
  reg  [7:0]  serialCtl_reg;
  reg  [7:0]  txHolding_reg;
  reg  [7:0]  rxHolding_reg;
  reg         bitOrder_reg;
  reg         dataInv_reg;
  reg         cardEn_reg;
  reg         txEmpty_reg;
  reg         rxFull_reg;
  reg         overrun_reg;
  reg         errSig_reg;
  reg         parErr_reg;
  reg         txEnd_reg;
  reg         lineMeta_reg;
  reg         lineSync_reg;
  reg         linePrev_reg;
  reg         clkTgl_reg;
  reg         txState_reg;
  reg  [8:0]  txTicks_reg;
  reg  [4:0]  txHalf_reg;
  reg  [7:0]  txChar_reg;
  reg         txPar_reg;
  reg         txErr_reg;
  reg         txLow_reg;
  reg         txLoad_reg;
  reg         txEndSet_reg;
  reg         errSet_reg;
  reg         rxState_reg;
  reg  [8:0]  rxTicks_reg;
  reg  [4:0]  rxHalf_reg;
  reg  [7:0]  rxChar_reg;
  reg         rxBad_reg;
  reg         rxLow_reg;
  reg         rxDone_reg;
  reg         rxPerr_reg;
  reg         rxOvr_reg;
  reg  [7:0]  readData;
  wire        tick;
  wire        access;
  wire [19:0] regIdx;
  wire        hit;
  wire        wrEn;
  wire        wrStat;
  wire        modeOn;
  wire        txOn;
  wire        rxOn;
  wire        altMode;
  wire        oddSel;
  wire        txStep;
  wire        rxStep;
  wire [4:0]  txHalfNext;
  wire [4:0]  rxHalfNext;
  wire [3:0]  txHb;
  wire [3:0]  rxHb;
  wire [2:0]  txBitIdx;
  wire [2:0]  rxBitIdx;
  wire        rxParBad;

  // map between register byte and line order; reversing and inverting
  // commute, so one function serves both directions
  function [7:0] lineBits;
    input [7:0] d;
    input       msbFirst;
    input       inv;
    reg   [7:0] v;
    integer     k;
    begin
      v = inv ? ~d : d;
      lineBits = v;
      if (msbFirst) begin
        for (k = 0; k < 8; k = k + 1) begin
          lineBits[k] = v[7-k];
        end
      end
    end
  endfunction

  assign modeOn  = cardEn_reg;
  assign txOn    = modeOn & serialCtl_reg[`SC_C_TXEN];
  // no card clocked mode exists: only async frames are built
  // both enables may run together; own frame loops back
  assign rxOn    = modeOn & serialCtl_reg[`SC_C_RXEN];
  assign altMode = serialModeCtl_reg[`SC_M_ALT];
  assign oddSel  = serialModeCtl_reg[`SC_M_ODD];

  baud_tick_gen #(
    .DIV_W (8)
  ) u_tick (
    .core_clk (core_clk),
    .rst      (rst),
    .run      (modeOn),
    .clkSel   (serialModeCtl_reg[`SC_M_CLKSEL_HI:`SC_M_CLKSEL_LO]),
    .divisor  (bitRateDiv_reg),
    .tick     (tick)
  );

  // apb: one wait state, answer registered
  assign access = psel & penable;
  assign regIdx = paddr[21:2];
  assign hit    = (regIdx >= `SC_IDX_MODE) && (regIdx <= `SC_IDX_CMS);
  assign wrEn   = access & pready & pwrite & hit;
  assign wrStat = wrEn && (regIdx == `SC_IDX_STAT);

  always @* begin
    case (regIdx)
      `SC_IDX_MODE: readData = serialModeCtl_reg;
      `SC_IDX_DIV:  readData = bitRateDiv_reg;
      `SC_IDX_CTRL: readData = serialCtl_reg;
      `SC_IDX_TXH:  readData = txHolding_reg;
      `SC_IDX_STAT: readData = {txEmpty_reg, rxFull_reg, overrun_reg,
                                errSig_reg, parErr_reg, txEnd_reg, 2'b00};
      `SC_IDX_RXH:  readData = rxHolding_reg;
      `SC_IDX_CMS:  readData = `SC_K_FIXED |
                               {4'h0, bitOrder_reg, dataInv_reg, 1'b0,
                                cardEn_reg};
      default:      readData = 8'h00;
    endcase
  end

  always @(posedge core_clk) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= access & ~pready;
      pslverr <= access & ~pready & ~hit;
      if (access & ~pready) begin
        prdata <= {24'h000000, readData};
      end
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      serialModeCtl_reg <= `SC_RST_MODE;
      bitRateDiv_reg    <= `SC_RST_DIV;
      serialCtl_reg     <= `SC_RST_CTRL;
      txHolding_reg     <= `SC_RST_TXH;
      bitOrder_reg      <= `SC_RST_ORDER;
      dataInv_reg       <= `SC_RST_INV;
      cardEn_reg        <= `SC_RST_EN;
    end else if (wrEn) begin
      case (regIdx)
        `SC_IDX_MODE: serialModeCtl_reg <= pwdata[7:0];
        `SC_IDX_DIV:  bitRateDiv_reg    <= pwdata[7:0];
        `SC_IDX_CTRL: serialCtl_reg     <= pwdata[7:0];
        `SC_IDX_TXH:  txHolding_reg     <= pwdata[7:0];
        `SC_IDX_CMS: begin
          bitOrder_reg <= pwdata[`SC_K_ORDER];
          dataInv_reg  <= pwdata[`SC_K_INV];
          cardEn_reg   <= pwdata[`SC_K_EN];
        end
        default: ;
      endcase
    end
  end

  // status flags: hardware set wins over a software clear
  always @(posedge core_clk) begin
    if (rst) begin
      txEmpty_reg <= 1'b1;
      rxFull_reg  <= 1'b0;
      overrun_reg <= 1'b0;
      errSig_reg  <= 1'b0;
      parErr_reg  <= 1'b0;
      txEnd_reg   <= 1'b1;
    end else begin
      txEmpty_reg <= txLoad_reg |
                     (txEmpty_reg & ~(wrStat & ~pwdata[`SC_S_TXEMPTY]));
      rxFull_reg  <= rxDone_reg |
                     (rxFull_reg & ~(wrStat & ~pwdata[`SC_S_RXFULL]));
      overrun_reg <= rxOvr_reg |
                     (overrun_reg & ~(wrStat & ~pwdata[`SC_S_OVERRUN]));
      errSig_reg  <= errSet_reg |
                     (errSig_reg & ~(wrStat & ~pwdata[`SC_S_ERRSIG]));
      parErr_reg  <= rxPerr_reg |
                     (parErr_reg & ~(wrStat & ~pwdata[`SC_S_PARERR]));
      txEnd_reg   <= txEndSet_reg |
                     (~serialCtl_reg[`SC_C_TXEN] & ~errSig_reg) |
                     (txEnd_reg & ~(wrStat & ~pwdata[`SC_S_TXEMPTY]));
    end
  end

  // line input crosses in through two flip-flops
  always @(posedge core_clk) begin
    if (rst) begin
      lineMeta_reg <= 1'b1;
      lineSync_reg <= 1'b1;
      linePrev_reg <= 1'b1;
    end else begin
      lineMeta_reg <= dataIn;
      lineSync_reg <= lineMeta_reg;
      linePrev_reg <= lineSync_reg;
    end
  end

  assign txStep     = tick && (txTicks_reg == `SC_TICKS_HALF_ETU - 9'd1);
  assign txHalfNext = txHalf_reg + 5'd1;
  assign txHb       = txHalfNext[4:1];
  assign txBitIdx   = txHb[2:0] - 3'd1;

  // transmitter: start at half 0, data bit i at 2+2i, parity at 18
  always @(posedge core_clk) begin
    if (rst || !txOn) begin
      txState_reg  <= TX_IDLE;
      txTicks_reg  <= 9'd0;
      txHalf_reg   <= 5'd0;
      txChar_reg   <= 8'h00;
      txPar_reg    <= 1'b0;
      txErr_reg    <= 1'b0;
      txLow_reg    <= 1'b0;
      txLoad_reg   <= 1'b0;
      txEndSet_reg <= 1'b0;
      errSet_reg   <= 1'b0;
    end else begin
      txLoad_reg   <= 1'b0;
      txEndSet_reg <= 1'b0;
      errSet_reg   <= 1'b0;
      case (txState_reg)
        TX_IDLE: begin
          if (!txEmpty_reg) begin
            txState_reg <= TX_RUN;
            txTicks_reg <= 9'd0;
            txHalf_reg  <= 5'd0;
            txChar_reg  <= lineBits(txHolding_reg, bitOrder_reg,
                                    dataInv_reg);
            // parity counts line levels, so the invert is already in
            txPar_reg   <= ^lineBits(txHolding_reg, bitOrder_reg,
                                     dataInv_reg) ^ oddSel;
            txErr_reg   <= 1'b0;
            txLow_reg   <= 1'b1;
            txLoad_reg  <= 1'b1;
          end
        end
        TX_RUN: begin
          if (tick) begin
            txTicks_reg <= txStep ? 9'd0 : txTicks_reg + 9'd1;
          end
          if (txStep) begin
            txHalf_reg <= txHalfNext;
            if (!txHalfNext[0] && txHalfNext <= `SC_H_DATA_LAST) begin
              txLow_reg <= ~txChar_reg[txBitIdx];
            end
            if (txHalfNext == `SC_H_PARITY) begin
              txLow_reg <= ~txPar_reg;
            end
            if (txHalfNext == `SC_H_RELEASE) begin
              txLow_reg <= 1'b0;
            end
            if (txHalfNext == `SC_H_ERR_SAMP) begin
              txErr_reg  <= ~lineSync_reg;
              errSet_reg <= ~lineSync_reg;
            end
            if (altMode && txHalfNext == `SC_H_END_ALT) begin
              txEndSet_reg <= lineSync_reg & txEmpty_reg;
            end
            if (!altMode && txHalfNext == `SC_H_END_NORM) begin
              txEndSet_reg <= ~txErr_reg & txEmpty_reg;
            end
            // next start no sooner than 2 etu past the parity end
            if (txHalfNext == `SC_H_END_NORM && !txErr_reg) begin
              txState_reg <= TX_IDLE;
            end
            if (txHalfNext == `SC_H_RETRY) begin
              txHalf_reg <= 5'd0;
              txErr_reg  <= 1'b0;
              txLow_reg  <= 1'b1;
            end
          end
        end
        default: txState_reg <= TX_IDLE;
      endcase
    end
  end

  assign rxStep     = tick && (rxTicks_reg == `SC_TICKS_HALF_ETU - 9'd1);
  assign rxHalfNext = rxHalf_reg + 5'd1;
  assign rxHb       = rxHalfNext[4:1];
  assign rxBitIdx   = rxHb[2:0] - 3'd1;
  assign rxParBad   = (^rxChar_reg ^ lineSync_reg) != oddSel;

  // receiver samples at odd half points, mid of each etu
  always @(posedge core_clk) begin
    if (rst || !rxOn) begin
      rxState_reg   <= RX_IDLE;
      rxTicks_reg   <= 9'd0;
      rxHalf_reg    <= 5'd0;
      rxChar_reg    <= 8'h00;
      rxBad_reg     <= 1'b0;
      rxLow_reg     <= 1'b0;
      rxDone_reg    <= 1'b0;
      rxPerr_reg    <= 1'b0;
      rxOvr_reg     <= 1'b0;
      rxHolding_reg <= `SC_RST_RXH;
    end else begin
      rxDone_reg <= 1'b0;
      rxPerr_reg <= 1'b0;
      rxOvr_reg  <= 1'b0;
      case (rxState_reg)
        RX_IDLE: begin
          if (linePrev_reg && !lineSync_reg) begin
            rxState_reg <= RX_RUN;
            rxTicks_reg <= 9'd0;
            rxHalf_reg  <= 5'd0;
            rxBad_reg   <= 1'b0;
          end
        end
        RX_RUN: begin
          if (tick) begin
            rxTicks_reg <= rxStep ? 9'd0 : rxTicks_reg + 9'd1;
          end
          if (rxStep) begin
            rxHalf_reg <= rxHalfNext;
            // a start shorter than half an etu is a glitch
            if (rxHalfNext == `SC_H_START_CHK && lineSync_reg) begin
              rxState_reg <= RX_IDLE;
            end
            if (rxHalfNext[0] && rxHalfNext > `SC_H_START_CHK &&
                rxHalfNext <= `SC_H_DATA_LAST) begin
              rxChar_reg[rxBitIdx] <= lineSync_reg;
            end
            if (rxHalfNext == `SC_H_RX_PAR) begin
              rxBad_reg <= rxParBad;
              if (rxParBad) begin
                rxPerr_reg <= 1'b1;
              end else if (rxFull_reg) begin
                rxOvr_reg <= 1'b1;
              end else begin
                rxHolding_reg <= lineBits(rxChar_reg, bitOrder_reg,
                                          dataInv_reg);
                rxDone_reg    <= 1'b1;
              end
            end
            if (rxHalfNext == `SC_H_ERR_ON && rxBad_reg) begin
              rxLow_reg <= 1'b1;
            end
            if (rxHalfNext == `SC_H_ERR_OFF) begin
              rxLow_reg   <= 1'b0;
              rxState_reg <= RX_IDLE;
            end
          end
        end
        default: rxState_reg <= RX_IDLE;
      endcase
    end
  end

  // pins; the data line is only ever pulled low, never driven high
  always @(posedge core_clk) begin
    if (rst) begin
      dataOut    <= 1'b0;
      dataOe     <= 1'b0;
      clkTgl_reg <= 1'b0;
      cardClkOut <= 1'b0;
      cardClkOe  <= 1'b0;
    end else begin
      dataOut <= 1'b0;
      dataOe  <= txLow_reg | rxLow_reg;
      if (tick) begin
        clkTgl_reg <= ~clkTgl_reg;
      end
      if (!modeOn) begin
        cardClkOe  <= 1'b0;
        cardClkOut <= 1'b0;
      end else if (serialCtl_reg[`SC_C_CLKLO]) begin
        cardClkOe  <= 1'b1;
        cardClkOut <= clkTgl_reg;
      end else if (altMode && serialCtl_reg[`SC_C_CLKHI]) begin
        cardClkOe  <= 1'b1;
        cardClkOut <= 1'b0;
      end else if (altMode) begin
        cardClkOe  <= 1'b1;
        cardClkOut <= 1'b1;
      end else begin
        // upper enable alone without alternate timing acts as port
        cardClkOe  <= 1'b0;
        cardClkOut <= 1'b0;
      end
    end
  end

endmodule // smart_card_serial_mode

// *** test/smart_card_serial_mode_assertions.sv ***
// concurrent checks on the card port bus and pin outputs
`timescale 1ns/10ps
module smart_card_serial_mode_assertions (
  // clock and reset
  input wire        core_clk,
  input wire        rst,
  // apb slave
  input wire [21:0] paddr,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // data line
  input wire        dataIn,
  input wire        dataOut,
  input wire        dataOe,
  // card clock
  input wire        cardClkOut,
  input wire        cardClkOe
);
  // longest legal pull: start, eight zero data bits, zero parity, plus slack
  localparam int MAX_LOW = 7448;
  int lowRun;

  always @(posedge core_clk) begin
    if (rst || !dataOe) lowRun <= 0;
    else lowRun <= lowRun + 1;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_setup;  psel && !penable; endsequence
  sequence s_access; psel && penable && !pready; endsequence

  property p_waitState; s_setup |=> !pready; endproperty
  a_waitState: assert property (p_waitState) else $error("early ready");
  property p_answer; s_setup ##1 s_access |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("ready late");
  property p_readyPulse; pready |=> !pready; endproperty
  a_readyPulse: assert property (p_readyPulse) else $error("ready stuck");
  property p_slvErr; pslverr |-> pready; endproperty
  a_slvErr: assert property (p_slvErr) else $error("stray slave error");
  property p_upperZero; pready |-> prdata[31:8] == 24'h0; endproperty
  a_upperZero: assert property (p_upperZero) else $error("upper data set");
  property p_openDrain; dataOut == 1'b0; endproperty
  a_openDrain: assert property (p_openDrain) else $error("line driven high");
  property p_lowRun; lowRun <= MAX_LOW; endproperty
  a_lowRun: assert property (p_lowRun) else $error("line held low too long");
  property p_resetQuiet; $fell(rst) |-> !dataOe && !cardClkOe && !pready;
  endproperty
  a_resetQuiet: assert property (p_resetQuiet) else $error("pins busy at reset");
endmodule // smart_card_serial_mode_assertions

bind smart_card_serial_mode smart_card_serial_mode_assertions u_chk (
  .core_clk(core_clk), .rst(rst), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .dataIn(dataIn), .dataOut(dataOut),
  .dataOe(dataOe), .cardClkOut(cardClkOut), .cardClkOe(cardClkOe));

// *** test/card_model.sv ***
// card stand-in on the shared data line: sends, receives, returns errors
`timescale 1ns/10ps
module card_model #(
  parameter int ETU = 744
) (
  // clock
  input  wire  core_clk,
  // shared line
  input  wire  lineLvl,
  output logic cardPull
);
  logic [8:0] rxBits;
  logic       sending;
  logic       errSeen;
  int         errCount;
  int         k;

  initial begin
    cardPull = 1'b0;
    sending = 1'b0;
    errSeen = 1'b0;
    errCount = 0;
    rxBits = 9'h000;
  end

  // mid-etu sampling stays clear of the receiver's sync lag
  always begin
    @(negedge lineLvl);
    if (!sending) begin
      repeat (ETU + ETU / 2) @(posedge core_clk);
      for (k = 0; k < 9; k++) begin
        rxBits[k] = lineLvl;
        if (k < 8) repeat (ETU) @(posedge core_clk);
      end
      repeat (ETU) @(posedge core_clk);
      // error only when a scenario asks for one
      if (errCount > 0) begin
        errCount--;
        cardPull <= 1'b1;
        repeat (ETU) @(posedge core_clk);
        cardPull <= 1'b0;
      end
      repeat (ETU / 2) @(posedge core_clk);
    end
  end

  task send(input [8:0] bits);
    int j;
    begin
      sending = 1'b1;
      errSeen = 1'b0;
      @(posedge core_clk);
      cardPull <= 1'b1;
      repeat (ETU) @(posedge core_clk);
      for (j = 0; j < 9; j++) begin
        cardPull <= ~bits[j];
        repeat (ETU) @(posedge core_clk);
      end
      cardPull <= 1'b0;
      repeat (ETU) @(posedge core_clk);
      errSeen = !lineLvl;
      repeat (ETU) @(posedge core_clk);
      sending = 1'b0;
    end
  endtask
endmodule // card_model

// *** test/testbench.sv ***
// self-checking bench: apb register tasks plus card line scenarios
`timescale 1ns/10ps
module testbench;
  localparam int        HALF = 372;
  localparam int        ETU  = 744;
  localparam [19:0]     BASE = 20'hfffb0;
  reg                   core_clk = 1'b0;
  reg                   rst = 1'b1;
  reg                   psel = 1'b0;
  reg                   penable = 1'b0;
  reg                   pwrite = 1'b0;
  reg  [21:0]           paddr = 22'h0;
  reg  [31:0]           pwdata = 32'h0;
  wire [31:0]           prdata;
  wire                  pready, pslverr, dataOut, dataOe;
  wire                  cardClkOut, cardClkOe, cardPull;
  // pull-up holds the line high unless someone pulls it low
  wire                  lineLvl = ~(dataOe | cardPull);
  integer               mismatches = 0;
  integer               samples_checked = 0;
  integer               cyc = 0;
  integer               t0, t1, n;
  reg  [31:0]           rdv;
  reg                   errv;

  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;

  smart_card_serial_mode u_dut (.core_clk(core_clk), .rst(rst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dataIn(lineLvl), .dataOut(dataOut), .dataOe(dataOe),
    .cardClkOut(cardClkOut), .cardClkOe(cardClkOe));
  card_model #(.ETU(ETU)) u_card (.core_clk(core_clk), .lineLvl(lineLvl),
    .cardPull(cardPull));

  task conclude;
    begin
      $display("compares %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    begin
      samples_checked++;
      if (got !== exp) begin
        mismatches++;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // request holds until pready is seen high at a rising edge
  task apb(input w, input [3:0] off, input [7:0] wd);
    integer k;
    begin
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {BASE + {16'h0, off}, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge core_clk);
      penable <= 1'b1;
      k = 0;
      @(posedge core_clk);
      while (pready !== 1'b1 && k < 50) begin
        @(posedge core_clk);
        k++;
      end
      if (k >= 50) begin
        mismatches++;
        $display("[ERR] %0t no bus answer", $time);
      end
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task wr(input [3:0] off, input [7:0] d);
    apb(1'b1, off, d);
  endtask

  task rd(input [3:0] off, input [7:0] mask, input [7:0] exp);
    begin
      apb(1'b0, off, 8'h00);
      chk({24'h0, rdv[7:0] & mask}, {24'h0, exp});
    end
  endtask

  task waitStart;
    integer k;
    begin
      k = 0;
      @(negedge core_clk);
      while (dataOe !== 1'b1 && k < 3 * ETU) begin
        @(negedge core_clk);
        k++;
      end
      if (k >= 3 * ETU) begin
        mismatches++;
        $display("[ERR] %0t no frame start", $time);
      end
      t0 = cyc;
    end
  endtask

  task untilH(input integer h);
    while (cyc < t0 + h * HALF) @(posedge core_clk);
  endtask

  // expTog below zero leaves the toggle count unchecked
  task clkCase(input [7:0] mode, input [7:0] ctrl, input integer expOe,
               input integer expLvl, input integer expTog);
    integer j;
    reg     last;
    begin
      wr(0, mode);
      wr(2, ctrl);
      repeat (20) @(negedge core_clk);
      n = 0;
      last = cardClkOut;
      for (j = 0; j < 64; j++) begin
        @(negedge core_clk);
        if (cardClkOut !== last) n++;
        last = cardClkOut;
      end
      chk(cardClkOe, expOe);
      if (expTog >= 0) chk(n, expTog);
      if (expLvl < 2) chk(cardClkOut, expLvl);
    end
  endtask

  function automatic [8:0] frameBits(input [7:0] d, input conv);
    integer i;
    reg [7:0] l;
    begin
      for (i = 0; i < 8; i++) l[i] = conv ? ~d[7 - i] : d[i];
      frameBits = {^l ^ conv, l};
    end
  endfunction

  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rd(0, 8'hff, 8'h00);
    rd(1, 8'hff, 8'hff);
    rd(2, 8'hff, 8'h00);
    rd(3, 8'hff, 8'hff);
    rd(4, 8'hff, 8'h84);
    rd(5, 8'hff, 8'h00);
    rd(6, 8'hff, 8'hf2);
    apb(1'b0, 4'd7, 8'h00);
    chk(errv, 1);
    chk(rdv, 0);
    wr(5, 8'h77);
    rd(5, 8'hff, 8'h00);
    wr(1, 8'h00);
    clkCase(8'h00, 8'h01, 0, 2, -1);
    wr(6, 8'h01);
    rd(6, 8'hff, 8'hf3);
    clkCase(8'h00, 8'h01, 1, 2, 64);
    clkCase(8'h00, 8'h00, 0, 2, -1);
    clkCase(8'h80, 8'h02, 1, 0, 0);
    clkCase(8'h80, 8'h00, 1, 1, 0);
    clkCase(8'h80, 8'h03, 1, 2, 64);
    clkCase(8'h01, 8'h01, 1, 2, 16);
    clkCase(8'h02, 8'h01, 1, 2, 4);
    clkCase(8'h03, 8'h01, 1, 2, 1);
    wr(0, 8'h28);
    wr(2, 8'h21);
    wr(3, 8'h3b);
    wr(4, 8'h7f);
    waitStart;
    untilH(24);
    rd(4, 8'h04, 8'h00);
    untilH(26);
    rd(4, 8'h04, 8'h04);
    chk(u_card.rxBits, frameBits(8'h3b, 1'b0));
    wr(0, 8'hb8);
    wr(6, 8'h0d);
    wr(3, 8'h3f);
    wr(4, 8'h7f);
    waitStart;
    untilH(21);
    rd(4, 8'h04, 8'h00);
    untilH(23);
    rd(4, 8'h04, 8'h04);
    chk(u_card.rxBits, frameBits(8'h3f, 1'b1));
    u_card.errCount = 1;
    wr(3, 8'h5a);
    wr(4, 8'h7f);
    waitStart;
    t1 = t0;
    untilH(25);
    rd(4, 8'h14, 8'h10);
    waitStart;
    chk(t0 - t1 >= 27 * HALF - 4 && t0 - t1 <= 28 * HALF, 1);
    untilH(26);
    chk(u_card.rxBits, frameBits(8'h5a, 1'b1));
    wr(2, 8'h11);
    wr(0, 8'h28);
    wr(6, 8'h01);
    wr(4, 8'h80);
    u_card.send(frameBits(8'ha5, 1'b0));
    chk(u_card.errSeen, 0);
    rd(5, 8'hff, 8'ha5);
    rd(4, 8'h48, 8'h40);
    wr(4, 8'hbf);
    u_card.send(frameBits(8'h3c, 1'b0) ^ 9'h100);
    chk(u_card.errSeen, 1);
    chk(dataOe, 0);
    rd(4, 8'h48, 8'h08);
    rd(5, 8'hff, 8'ha5);
    wr(4, 8'h80);
    wr(3, 8'h96);
    wr(2, 8'h31);
    wr(4, 8'h7f);
    waitStart;
    untilH(26);
    rd(5, 8'hff, 8'h96);
    conclude;
  end

  initial begin
    repeat (95000) @(posedge core_clk);
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude;
  end
endmodule // testbench
